// ===== kbsr_buf.sv
// two-entry scan code buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module kbsr_buf
	import kbsr_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire kbsr_byte_type in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output kbsr_byte_type out_data_out
);
	kbsr_byte_type mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_ready_out = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem[rd_ptr];

	// storage, written only on an accepted push
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
		end
		else if (push)
			mem[wr_ptr] <= in_data_in;
	end

	// pointers and occupancy
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule // kbsr_buf
`default_nettype wire

// ===== kbsr_kbd_model.sv
// keyboard model: open-drain clock and data, one frame per call
`timescale 1ns/1ps
`default_nettype none
module kbsr_kbd_model
(
	// selected clock wire level
	input wire logic clk_line_in,
	// pull-low enables
	output logic clk_pull_out,
	output logic dat_pull_out
);
	// lines released at time zero
	initial
	begin
		clk_pull_out = 1'b0;
		dat_pull_out = 1'b0;
	end
	// start bit, then data lsb first; data moves only while clock is high
	task automatic send(input logic [7:0] code, input int half);
		logic [8:0] bits;
		bits = {code, 1'b1};
		wait (clk_line_in === 1'b1); // device may still hold the clock
		for (int i = 0; i < 9; i++)
		begin
			dat_pull_out = !bits[i];
			#(half);
			clk_pull_out = 1'b1;
			#(half);
			clk_pull_out = 1'b0;
		end
		dat_pull_out = 1'b0;
	endtask
endmodule // kbsr_kbd_model
`default_nettype wire

// ===== kbsr_link.sv
// nine-bit shifter clocked by the keyboard's own serial clock
`timescale 1ns/1ps
`default_nettype none
`include "kbsr_regs.svh"
module kbsr_link
	import kbsr_pkg::*;
(
	// link clock and reset
	input wire logic kbd_serial_clock_in,
	input wire logic rst_n_in,
	// selected serial data level
	input wire logic kbd_serial_data_in,
	// to the system core
	kbsr_link_if.link lnk
);
	logic [`KBSR_FRAME_BITS-1:0] shift;
	logic link_rst_n;

	// clear is a system-side flop; the keyboard clock is held low meanwhile
	assign link_rst_n = rst_n_in & ~lnk.clear;

	// sample on falling edges, lsb first, start bit ends in d0; frozen once full
	always_ff @(negedge kbd_serial_clock_in or negedge link_rst_n)
	begin
		if (!link_rst_n)
			shift <= `KBSR_SHIFT_RESET;
		else if (!shift[0])
			shift <= {kbd_serial_data_in, shift[`KBSR_FRAME_BITS-1:1]};
	end

	assign lnk.frame_done = shift[0];
	assign lnk.frame_code = shift[`KBSR_FRAME_BITS-1:1];
endmodule // kbsr_link
`default_nettype wire

// ===== kbsr_link_if.sv
// signals between the system-side core and the link-clock shifter
`timescale 1ns/1ps
`default_nettype none
interface kbsr_link_if;
	logic clear; // system side: hold shifter empty
	logic frame_done; // link side: start bit reached d0
	logic [7:0] frame_code; // link side: assembled scan code

	modport sys
	(
		output clear,
		input frame_done,
		input frame_code
	);

	modport link
	(
		input clear,
		output frame_done,
		output frame_code
	);
endinterface
`default_nettype wire

// ===== kbsr_pkg.sv
// types shared by the serial keyboard receiver modules
`default_nettype none
package kbsr_pkg;

	// capture sequencer, one-hot
	typedef enum logic [1:0]
	{
		KBSR_IDLE = 2'b01,
		KBSR_DRAIN = 2'b10
	} kbsr_cap_state_type;

	typedef logic [7:0] kbsr_byte_type;

endpackage
`default_nettype wire

// ===== kbsr_regs.svh
// register offsets, field positions and reset values of the serial keyboard receiver
`ifndef KBSR_REGS_SVH
`define KBSR_REGS_SVH

// direct i/o addresses
`define KBSR_SCAN_CODE_PORT_ADDR 8'h60
`define KBSR_CONTROL_PORT_ADDR 8'h61
// indexed configuration space
`define KBSR_SCAN_ENABLE_IDX 8'h66
`define KBSR_SHADOW_SHIFT_IDX 8'h68

// keyboard_control_port fields
`define KBSR_CTL_CLK_ENABLE_BIT 6
`define KBSR_CTL_CLEAR_BIT 7
`define KBSR_CTL_LEGACY_MSB 5
`define KBSR_CONTROL_RESET 8'h40

// scan_enable_config fields
`define KBSR_CFG_PRIMARY_BIT 3
`define KBSR_CFG_PAIR_BIT 0
`define KBSR_SCAN_ENABLE_RESET 8'h00

// frame shape: start bit plus eight data bits
`define KBSR_FRAME_BITS 9
`define KBSR_SHIFT_RESET 9'h000
`define KBSR_CODE_RESET 8'h00

`endif

// ===== kbsr_top.sv
// serial keyboard receiver: i/o registers, pin control and frame capture
`timescale 1ns/1ps
`default_nettype none
`include "kbsr_regs.svh"
module kbsr_top
	import kbsr_pkg::*;
(
	// system clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// keyboard serial clock as seen on the selected pin
	input wire logic kbd_serial_clock_in,
	// i/o access
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic io_index_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	output logic [7:0] io_rdata_out,
	// gpio port a pins, open drain
	input wire logic port_a_pin7_in,
	output logic port_a_pin7_out,
	output logic port_a_pin7_oe_out,
	input wire logic port_a_pin6_in,
	output logic port_a_pin6_out,
	output logic port_a_pin6_oe_out,
	input wire logic port_a_pin0_in,
	output logic port_a_pin0_out,
	output logic port_a_pin0_oe_out,
	input wire logic port_a_pin1_in,
	output logic port_a_pin1_out,
	output logic port_a_pin1_oe_out,
	// system side results
	output logic keyboard_interrupt_out,
	output logic [5:0] legacy_control_out,
	output logic scan_primary_select_out
);
	kbsr_link_if lnk ();

	kbsr_byte_type control_port;
	kbsr_byte_type scan_cfg;
	kbsr_byte_type matrix_code;
	logic matrix_pending;
	logic clear_prev;
	logic clear_rise;
	logic scan_primary_select;
	logic pair_low;
	logic done_meta;
	logic done_sync;
	logic clk_meta;
	logic clk_sync;
	logic clk_pin_level;
	logic link_clear;
	logic hold_lines;
	logic draining;
	logic kbd_reset_drive;
	logic clk_oe;
	logic dat_oe;
	logic kbd_serial_data;
	kbsr_cap_state_type state;
	kbsr_cap_state_type next_state;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	kbsr_byte_type buf_out_data;
	logic wr_ctl;
	logic wr_cfg;
	logic wr_code;
	kbsr_byte_type next_rdata;

	// configuration decode
	assign scan_primary_select = scan_cfg[`KBSR_CFG_PRIMARY_BIT];
	assign pair_low = scan_cfg[`KBSR_CFG_PAIR_BIT];
	assign scan_primary_select_out = scan_primary_select;
	assign legacy_control_out = control_port[`KBSR_CTL_LEGACY_MSB:0];

	// write strobes for each register
	assign wr_ctl = io_wr_in & ~io_index_in & (io_addr_in == `KBSR_CONTROL_PORT_ADDR);
	assign wr_cfg = io_wr_in & io_index_in & (io_addr_in == `KBSR_SCAN_ENABLE_IDX);
	// data port takes writes only from matrix software, read-only when serial
	assign wr_code = io_wr_in & ~io_index_in & (io_addr_in == `KBSR_SCAN_CODE_PORT_ADDR)
		& scan_primary_select;
	// 68h has no write strobe: the shadow is read-only

	// data selected on the chosen pair, sampled by the link clock itself
	assign kbd_serial_data = pair_low ? port_a_pin1_in : port_a_pin6_in;

	// link-clock shifter: falling-edge sampling, lsb first after start bit
	// it freezes once full, so later edges cannot spoil the waiting code
	kbsr_link u_link
	(
		.kbd_serial_clock_in(kbd_serial_clock_in),
		.rst_n_in(rst_n_in),
		.kbd_serial_data_in(kbd_serial_data),
		.lnk(lnk.link)
	);

	// keyboard control port: clock enable, clear and legacy bits
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			control_port <= `KBSR_CONTROL_RESET;
		else if (wr_ctl)
			control_port <= io_wdata_in;
	end

	// scan enable configuration
	// pair select should change only while the lines are idle
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			scan_cfg <= `KBSR_SCAN_ENABLE_RESET;
		else if (wr_cfg)
			scan_cfg <= io_wdata_in;
	end

	// clear acts on the rising edge of bit 7, so leaving it set does nothing more
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			clear_prev <= 1'b0;
		else
			clear_prev <= control_port[`KBSR_CTL_CLEAR_BIT];
	end

	assign clear_rise = control_port[`KBSR_CTL_CLEAR_BIT] & ~clear_prev;

	// completion level crosses from the link domain on two flops
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
		end
		else
		begin
			done_meta <= lnk.frame_done;
			done_sync <= done_meta;
		end
	end

	// status reads the selected clock pin itself, so a stuck pin shows up
	assign clk_pin_level = pair_low ? port_a_pin0_in : port_a_pin7_in;

	// clock level synchronised for status readback; reset high to match the idle line
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			clk_meta <= 1'b1;
			clk_sync <= 1'b1;
		end
		else
		begin
			clk_meta <= clk_pin_level;
			clk_sync <= clk_meta;
		end
	end

	// the code word is stable while done is seen: the shifter freezes when full
	assign buf_in_valid = (state == KBSR_IDLE) & done_sync;

	// capture sequencer: push the frame, then empty the shifter
	always_comb
	begin
		next_state = state;
		case (state)
			KBSR_IDLE:
			begin
				if (buf_in_valid && buf_in_ready)
					next_state = KBSR_DRAIN;
			end
			KBSR_DRAIN:
			begin
				if (!done_sync)
					next_state = KBSR_IDLE;
			end
			default:
				next_state = KBSR_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state <= KBSR_IDLE;
		else
			state <= next_state;
	end

	// sequencer is emptying the shifter; the lines stay held across it
	assign draining = (state == KBSR_DRAIN);

	// clear into the link domain is registered so its async reset is glitch free
	// keyboard reset empties the shifter too: our own pull on the clock is a false falling edge
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			link_clear <= 1'b0;
		else
			link_clear <= (next_state == KBSR_DRAIN) | kbd_reset_drive;
	end

	assign lnk.clear = link_clear;

	// received codes wait here; a full buffer stalls the capture sequencer
	// with the lines held until a pop, only one code waits here in practice
	kbsr_buf u_buf
	(
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(buf_in_valid),
		.in_ready_out(buf_in_ready),
		.in_data_in(lnk.frame_code),
		.out_valid_out(buf_out_valid),
		.out_ready_in(buf_out_ready),
		.out_data_out(buf_out_data)
	);

	// handler clear pops the head code in either mode
	assign buf_out_ready = clear_rise;

	// code written by matrix software when the scanner is primary
	// kept across a switch to serial, but then not returned at 60h
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			matrix_code <= `KBSR_CODE_RESET;
		else if (wr_code)
			matrix_code <= io_wdata_in;
	end

	// matrix pending: write sets, clear bit clears, a set in the same cycle wins
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			matrix_pending <= 1'b0;
		else if (wr_code)
			matrix_pending <= 1'b1;
		else if (clear_rise || !scan_primary_select)
			matrix_pending <= 1'b0;
	end

	// interrupt source follows the primary select
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			keyboard_interrupt_out <= 1'b0;
		else if (scan_primary_select)
			keyboard_interrupt_out <= matrix_pending;
		else
			keyboard_interrupt_out <= buf_out_valid;
	end

	// lines stay low from frame end until the handler has drained the code
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			hold_lines <= 1'b0;
		else
			// not link_clear: it also covers keyboard reset, which must leave data free
			hold_lines <= done_sync | buf_out_valid | draining;
	end

	// keyboard reset: clock low while enable bit is low
	// the pulse length is software's to choose; no minimum is imposed
	assign kbd_reset_drive = ~control_port[`KBSR_CTL_CLK_ENABLE_BIT];

	assign clk_oe = hold_lines | kbd_reset_drive;
	assign dat_oe = hold_lines;

	// open drain: drive only low, enable only on the chosen pair
	assign port_a_pin7_out = 1'b0;
	assign port_a_pin6_out = 1'b0;
	assign port_a_pin0_out = 1'b0;
	assign port_a_pin1_out = 1'b0;
	// pins of the unused pair stay released for matrix or gpio duties
	assign port_a_pin7_oe_out = ~pair_low & clk_oe;
	assign port_a_pin6_oe_out = ~pair_low & dat_oe;
	assign port_a_pin0_oe_out = pair_low & clk_oe;
	assign port_a_pin1_oe_out = pair_low & dat_oe;

	// read multiplexer; unmapped addresses read zero
	// 66h bits 2:1 are live status, so values written there do not read back
	always_comb
	begin
		next_rdata = 8'h00;
		if (!io_index_in)
		begin
			case (io_addr_in)
				`KBSR_SCAN_CODE_PORT_ADDR:
					next_rdata = scan_primary_select ? matrix_code : buf_out_data;
				`KBSR_CONTROL_PORT_ADDR:
					next_rdata = control_port;
				default:
					next_rdata = 8'h00;
			endcase
		end
		else
		begin
			case (io_addr_in)
				`KBSR_SCAN_ENABLE_IDX:
					next_rdata = {scan_cfg[7:3], clk_sync, buf_out_valid, scan_cfg[0]};
				`KBSR_SHADOW_SHIFT_IDX:
					next_rdata = buf_out_data;
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	// read data held in a register until the next read
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			io_rdata_out <= 8'h00;
		else if (io_rd_in)
			io_rdata_out <= next_rdata;
	end
endmodule // kbsr_top
`default_nettype wire

// ===== kbsr_top_chk.sv
// port assertions for the serial keyboard receiver
`timescale 1ns/1ps
`default_nettype none
module kbsr_top_chk
(
	// clock, reset, i/o
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic io_index_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic [7:0] io_rdata_out,
	// pins and results
	input wire logic port_a_pin7_out,
	input wire logic port_a_pin6_out,
	input wire logic port_a_pin0_out,
	input wire logic port_a_pin1_out,
	input wire logic port_a_pin7_oe_out,
	input wire logic port_a_pin6_oe_out,
	input wire logic port_a_pin0_oe_out,
	input wire logic port_a_pin1_oe_out,
	input wire logic keyboard_interrupt_out,
	input wire logic [5:0] legacy_control_out,
	input wire logic scan_primary_select_out
);
	logic [7:0] ctl;
	logic [7:0] cfg;
	logic [2:0] age;
	logic wr61, rd61, clr, clk_oe, dat_oe;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// a clear is bit 7 written 1 after 0
	assign wr61 = io_wr_in && !io_index_in && io_addr_in == 8'h61;
	assign rd61 = io_rd_in && !io_index_in && io_addr_in == 8'h61;
	assign clr = wr61 && io_wdata_in[7] && !ctl[7];
	assign clk_oe = cfg[0] ? port_a_pin0_oe_out : port_a_pin7_oe_out;
	assign dat_oe = cfg[0] ? port_a_pin1_oe_out : port_a_pin6_oe_out;
	// shadow of the writable registers
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			ctl <= 8'h40;
			cfg <= 8'h00;
		end
		else if (io_wr_in)
		begin
			if (wr61)
				ctl <= io_wdata_in;
			if (io_index_in && io_addr_in == 8'h66)
				cfg <= io_wdata_in;
		end
	// cycles since the last clear, saturating
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			age <= 3'h7;
		else if (clr)
			age <= 3'h0;
		else if (age != 3'h7)
			age <= age + 3'h1;
	open_drain_a: assert property (!(port_a_pin7_out | port_a_pin6_out | port_a_pin0_out | port_a_pin1_out))
		else $error("pin driven high");
	clock_hold_a: assert property (clk_oe == (!ctl[6] || dat_oe))
		else $error("clock pull wrong");
	legacy_copy_a: assert property (legacy_control_out == ctl[5:0])
		else $error("legacy bits wrong");
	ctl_read_a: assert property (rd61 |=> io_rdata_out == $past(ctl))
		else $error("control read wrong");
	select_copy_a: assert property (scan_primary_select_out == cfg[3])
		else $error("select wrong");
	irq_ack_a: assert property (keyboard_interrupt_out && !cfg[3] |-> clk_oe && dat_oe)
		else $error("irq without hold");
	clear_drop_a: assert property (clr |-> ##[1:4] !keyboard_interrupt_out && !dat_oe)
		else $error("clear ignored");
	held_till_a: assert property ($fell(dat_oe) |-> age < 3'h6)
		else $error("early release");
	cover property ($rose(keyboard_interrupt_out));
	cover property (clr ##2 !dat_oe);
	cover property (cfg[3] && dat_oe);
endmodule // kbsr_top_chk
bind kbsr_top kbsr_top_chk chk
(
	.mclk_in, .rst_n_in, .io_rd_in, .io_wr_in, .io_index_in, .io_addr_in, .io_wdata_in, .io_rdata_out,
	.port_a_pin7_out, .port_a_pin6_out, .port_a_pin0_out, .port_a_pin1_out,
	.port_a_pin7_oe_out, .port_a_pin6_oe_out, .port_a_pin0_oe_out, .port_a_pin1_oe_out,
	.keyboard_interrupt_out, .legacy_control_out, .scan_primary_select_out
);
`default_nettype wire

// ===== kbsr_top_tb.sv
// self-checking bench for the serial keyboard receiver
`timescale 1ns/1ps
`default_nettype none
module kbsr_top_tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic io_rd_in = 1'b0;
	logic io_wr_in = 1'b0;
	logic io_index_in = 1'b0;
	logic [7:0] io_addr_in = 8'h00;
	logic [7:0] io_wdata_in = 8'h00;
	logic pair = 1'b0;
	logic rd_q = 1'b0;
	logic [7:0] r;
	logic [7:0] exp_q[$];
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire [7:0] io_rdata_out;
	wire [3:0] po, oe;
	wire [5:0] leg;
	wire irq, sel, kc, kd;
	// open-drain wires with pull-ups; bits are pins 7, 6, 0, 1
	wire c7 = !(oe[3] || (!pair && kc));
	wire d6 = !(oe[2] || (!pair && kd));
	wire c0 = !(oe[1] || (pair && kc));
	wire d1 = !(oe[0] || (pair && kd));
	wire kclk = pair ? c0 : c7;
	wire dsel = pair ? oe[0] : oe[2];
	kbsr_top dut
	(
		.mclk_in, .rst_n_in, .kbd_serial_clock_in(kclk),
		.io_rd_in, .io_wr_in, .io_index_in, .io_addr_in, .io_wdata_in, .io_rdata_out,
		.port_a_pin7_in(c7), .port_a_pin7_out(po[3]), .port_a_pin7_oe_out(oe[3]),
		.port_a_pin6_in(d6), .port_a_pin6_out(po[2]), .port_a_pin6_oe_out(oe[2]),
		.port_a_pin0_in(c0), .port_a_pin0_out(po[1]), .port_a_pin0_oe_out(oe[1]),
		.port_a_pin1_in(d1), .port_a_pin1_out(po[0]), .port_a_pin1_oe_out(oe[0]),
		.keyboard_interrupt_out(irq), .legacy_control_out(leg), .scan_primary_select_out(sel)
	);
	kbsr_kbd_model kbd (.clk_line_in(kclk), .clk_pull_out(kc), .dat_pull_out(kd));
	// 200 mhz system clock
	initial
		forever #2.5 mclk_in = !mclk_in;
	task automatic report_and_stop;
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// read data lands one cycle after the read; also the hang limit
	always @(posedge mclk_in)
	begin
		if (rd_q)
			check("rdata", io_rdata_out, exp_q.pop_front());
		rd_q <= io_rd_in;
		cyc++;
		if (cyc == 4000)
		begin
			failures++;
			report_and_stop();
		end
	end
	// one access; strobe low for a cycle so the next one sees an edge
	task automatic acc(input logic w, input logic ix, input logic [7:0] a, input logic [7:0] d);
		io_index_in = ix;
		io_addr_in = a;
		io_wdata_in = d;
		io_wr_in = w;
		io_rd_in = !w;
		@(posedge mclk_in);
		#1;
		io_wr_in = 1'b0;
		io_rd_in = 1'b0;
		@(posedge mclk_in);
		#1;
	endtask
	task automatic rd(input logic ix, input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(1'b0, ix, a, 8'h00);
	endtask
	task automatic waitd(input logic v);
		@(posedge mclk_in);
		#1;
		for (int i = 0; i < 40 && dsel !== v; i++)
		begin
			@(posedge mclk_in);
			#1;
		end
	endtask
	// one frame on pin pair p, matrix primary when m
	task automatic frame(input logic p, input logic m, input int h);
		logic [7:0] c;
		c = 8'($urandom);
		pair = p;
		acc(1'b1, 1'b1, 8'h66, {4'h0, m, 2'b00, p});
		check("sel", {7'h00, sel}, {7'h00, m});
		rd(1'b1, 8'h66, {4'h0, m, 2'b10, p});
		kbd.send(c, h);
		waitd(1'b1);
		check("irq", {7'h00, irq}, {7'h00, !m});
		check("clkoe", {7'h00, p ? oe[1] : oe[3]}, 8'h01);
		if (!m)
		begin
			acc(1'b1, 1'b0, 8'h60, ~c); // refused while serial primary
			rd(1'b0, 8'h60, c);
		end
		else
		begin
			acc(1'b1, 1'b0, 8'h60, ~c);
			check("mirq", {7'h00, irq}, 8'h01);
			rd(1'b0, 8'h60, ~c);
		end
		rd(1'b1, 8'h68, c);
		rd(1'b1, 8'h66, {4'h0, m, 2'b01, p});
		acc(1'b1, 1'b0, 8'h61, 8'h40);
		acc(1'b1, 1'b0, 8'h61, 8'hc0);
		waitd(1'b0);
		check("irq", {7'h00, irq}, 8'h00);
	endtask
	// main sequence
	initial
	begin
		void'($urandom(32'h3c1a4609));
		repeat (16) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		rd(1'b0, 8'h61, 8'h40);
		rd(1'b1, 8'h66, 8'h04);
		rd(1'b0, 8'h62, 8'h00);
		r = {2'b01, 6'($urandom)};
		acc(1'b1, 1'b0, 8'h61, r);
		rd(1'b0, 8'h61, r);
		check("legacy", {2'b00, leg}, {2'b00, r[5:0]});
		frame(1'b0, 1'b0, 32);
		frame(1'b1, 1'b0, 32);
		frame(1'b0, 1'b1, 32);
		acc(1'b1, 1'b0, 8'h61, 8'h00);
		check("kreset", {6'h00, c7, oe[3]}, 8'h01);
		check("kreset_dat", {7'h00, oe[2]}, 8'h00);
		acc(1'b1, 1'b0, 8'h61, 8'h40);
		check("kreset", {6'h00, c7, oe[3]}, 8'h02);
		frame(1'b0, 1'b0, 32);
		report_and_stop();
	end
endmodule // kbsr_top_tb
`default_nettype wire
